/* common/adc_ctl_pkg.sv */
// Package holding register map, field layout and timing constants of the converter control block
// Behaviour
// - Software clears done flag writing zero only
// - Start-source field picks software, timers or pin
// - Start source changed only while halted; not enforced, control register writes take effect at any time
// - Control bits 5:4, 1:0 read one, ignore writes
// - Speed field sets 530/266/134/68 state conversion
// - Speed changed only while run request zero; not enforced, control register writes take effect at any time
// - Result words read over byte bus, latched
// - Upper-byte read captures lower byte into latch
// - Lower-byte read returns latched byte
// - Master reads upper byte before lower byte
// - Lone lower-byte read gives unguaranteed value
// - Result in bits 15:6, low six zero
// - Single conversion clears run request when done
// - Pin falling edge sets run request when selected
`default_nettype none
package adc_ctl_pkg;
	localparam logic [3:0] ADDR_RESULT_A_HI = 4'h0;
	localparam logic [3:0] ADDR_RESULT_A_LO = 4'h1;
	localparam logic [3:0] ADDR_RESULT_B_HI = 4'h2;
	localparam logic [3:0] ADDR_RESULT_B_LO = 4'h3;
	localparam logic [3:0] ADDR_RESULT_C_HI = 4'h4;
	localparam logic [3:0] ADDR_RESULT_C_LO = 4'h5;
	localparam logic [3:0] ADDR_RESULT_D_HI = 4'h6;
	localparam logic [3:0] ADDR_RESULT_D_LO = 4'h7;
	localparam logic [3:0] ADDR_CTL_STATUS  = 4'h8;
	localparam logic [3:0] ADDR_CONTROL     = 4'h9;

	localparam int DONE_BIT   = 7;
	localparam int IE_BIT     = 6;
	localparam int RUN_BIT    = 5;
	localparam int SCAN_BIT   = 4;
	localparam logic [7:0] CTL_STATUS_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET    = 8'h33;
	localparam logic [7:0] CONTROL_RSVD     = 8'h33;
	localparam logic [7:0] CONTROL_WMASK    = 8'hCC;
	localparam logic [7:0] CTL_STATUS_WMASK = 8'h7F;
	localparam logic [15:0] RESULT_RESET    = 16'h0000;
	localparam logic [5:0] RESULT_PAD       = 6'h00;

	typedef enum logic [1:0] {
		SRC_SOFTWARE = 2'h0,
		SRC_TPU      = 2'h1,
		SRC_TIMER    = 2'h2,
		SRC_PIN      = 2'h3
	} start_source_t;

	localparam logic [9:0] CONV_STATES_0 = 10'h212;
	localparam logic [9:0] CONV_STATES_1 = 10'h10A;
	localparam logic [9:0] CONV_STATES_2 = 10'h086;
	localparam logic [9:0] CONV_STATES_3 = 10'h044;
	localparam logic [9:0] CONV_ONE      = 10'h001;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_DONE = 2'b11
	} conv_state_t;
endpackage
`default_nettype wire

/* common/adc_bus_if.sv */
// Interface joining the byte-wide bus master to the converter control block
`default_nettype none
interface adc_bus_if;
	logic       rd;
	logic       wr;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport device (input rd, input wr, input addr, input wdata, output rdata);
	modport master (output rd, output wr, output addr, output wdata, input rdata);
endinterface
`default_nettype wire

/* logic/adc_ctl_device.sv */
// Converter control, start logic and result readout through a byte latch
`default_nettype none
module adc_ctl_device (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	adc_bus_if.device        bus,
	input  wire logic        i_tpu_trig,
	input  wire logic        i_timer_trig,
	input  wire logic        i_ext_trig_n,
	input  wire logic [9:0]  i_sample,
	output logic      [3:0]  o_analog_sel,
	output logic             o_sel_valid,
	output logic             o_busy
);
	logic [7:0]  ctl_q;
	logic [7:0]  ctl_d;
	logic [7:0]  cfg_q;
	logic [15:0] res_q [4];
	logic [7:0]  temp_q;
	logic [7:0]  rdata_q;
	logic        pin_q;
	logic [9:0]  cnt_q;
	logic [1:0]  idx_q;
	adc_ctl_pkg::conv_state_t st_q;

	wire [1:0] src     = cfg_q[7:6];
	wire [1:0] speed   = cfg_q[3:2];
	wire [3:0] chan    = ctl_q[3:0];
	wire       scan    = ctl_q[adc_ctl_pkg::SCAN_BIT];
	wire       run     = ctl_q[adc_ctl_pkg::RUN_BIT];
	wire       wr_ctl  = bus.wr && bus.addr == adc_ctl_pkg::ADDR_CTL_STATUS;
	wire       wr_cfg  = bus.wr && bus.addr == adc_ctl_pkg::ADDR_CONTROL;
	wire       rd_hi   = bus.rd && !bus.addr[3] && !bus.addr[0];
	wire [1:0] rd_reg  = bus.addr[2:1];
	wire       pin_fall = pin_q && !i_ext_trig_n;
	wire       hw_start = (src == adc_ctl_pkg::SRC_TPU && i_tpu_trig)
		|| (src == adc_ctl_pkg::SRC_TIMER && i_timer_trig)
		|| (src == adc_ctl_pkg::SRC_PIN && pin_fall);
	wire [9:0] conv_len = (speed == 2'h0) ? adc_ctl_pkg::CONV_STATES_0 :
		(speed == 2'h1) ? adc_ctl_pkg::CONV_STATES_1 :
		(speed == 2'h2) ? adc_ctl_pkg::CONV_STATES_2 : adc_ctl_pkg::CONV_STATES_3;
	// Single mode: codes 0-3 and 14-15; scan: 0-3 as last channel of the group
	wire       sel_ok  = scan ? (chan[3:2] == 2'h0) : (chan[3:2] == 2'h0 || chan[3:1] == 3'h7);
	wire [1:0] reg_sel = scan ? idx_q : chan[1:0];
	wire [3:0] ain     = scan ? {2'h0, idx_q} : chan;
	wire       conv_end = st_q == adc_ctl_pkg::ST_CONV && cnt_q == adc_ctl_pkg::CONV_ONE;
	wire       scan_last = idx_q == chan[1:0];
	wire       set_done = conv_end && (!scan || scan_last);

	always_comb begin
		ctl_d = ctl_q;
		if (wr_ctl) begin
			ctl_d = (bus.wdata & adc_ctl_pkg::CTL_STATUS_WMASK) | (ctl_q & ~adc_ctl_pkg::CTL_STATUS_WMASK);
			// Done flag only clears on a written zero; a one leaves it alone
			ctl_d[adc_ctl_pkg::DONE_BIT] = ctl_q[adc_ctl_pkg::DONE_BIT] & bus.wdata[adc_ctl_pkg::DONE_BIT];
		end
		if (hw_start)
			ctl_d[adc_ctl_pkg::RUN_BIT] = 1'b1;
		if (conv_end && !scan)
			ctl_d[adc_ctl_pkg::RUN_BIT] = 1'b0;
		// Set beats a simultaneous clear
		if (set_done)
			ctl_d[adc_ctl_pkg::DONE_BIT] = 1'b1;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctl_q <= adc_ctl_pkg::CTL_STATUS_RESET;
			cfg_q <= adc_ctl_pkg::CONTROL_RESET;
			pin_q <= 1'b1;
		end else begin
			ctl_q <= ctl_d;
			pin_q <= i_ext_trig_n;
			if (wr_cfg)
				cfg_q <= (bus.wdata & adc_ctl_pkg::CONTROL_WMASK) | adc_ctl_pkg::CONTROL_RSVD;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q  <= adc_ctl_pkg::ST_IDLE;
			cnt_q <= '0;
			idx_q <= 2'h0;
		end else begin
			case (st_q)
				adc_ctl_pkg::ST_IDLE: begin
					idx_q <= 2'h0;
					if (run && sel_ok) begin
						st_q  <= adc_ctl_pkg::ST_CONV;
						cnt_q <= conv_len;
					end
				end
				adc_ctl_pkg::ST_CONV: begin
					if (!run)
						st_q <= adc_ctl_pkg::ST_IDLE;
					else if (conv_end)
						st_q <= adc_ctl_pkg::ST_DONE;
					else
						cnt_q <= cnt_q - adc_ctl_pkg::CONV_ONE;
				end
				adc_ctl_pkg::ST_DONE: begin
					if (scan && run) begin
						st_q  <= adc_ctl_pkg::ST_CONV;
						cnt_q <= conv_len;
						idx_q <= scan_last ? 2'h0 : idx_q + 2'h1;
					end else begin
						st_q <= adc_ctl_pkg::ST_IDLE;
					end
				end
				default: st_q <= adc_ctl_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			res_q[0] <= adc_ctl_pkg::RESULT_RESET;
			res_q[1] <= adc_ctl_pkg::RESULT_RESET;
			res_q[2] <= adc_ctl_pkg::RESULT_RESET;
			res_q[3] <= adc_ctl_pkg::RESULT_RESET;
		end else if (conv_end && run) begin
			res_q[reg_sel] <= {i_sample, adc_ctl_pkg::RESULT_PAD};
		end
	end

	wire [7:0] rd_mux = (bus.addr == adc_ctl_pkg::ADDR_CTL_STATUS) ? ctl_q :
		(bus.addr == adc_ctl_pkg::ADDR_CONTROL) ? cfg_q :
		bus.addr[3] ? 8'h00 :
		rd_hi ? res_q[rd_reg][15:8] : temp_q;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			temp_q  <= 8'h00;
			rdata_q <= 8'h00;
		end else begin
			if (rd_hi)
				temp_q <= res_q[rd_reg][7:0];
			if (bus.rd)
				rdata_q <= rd_mux;
		end
	end

	assign bus.rdata    = rdata_q;
	assign o_analog_sel = ain;
	assign o_sel_valid  = sel_ok;
	assign o_busy       = st_q != adc_ctl_pkg::ST_IDLE;
endmodule
`default_nettype wire

/* logic/adc_bus_master.sv */
// Bus master end: register writes and ordered two-byte result reads
`default_nettype none
module adc_bus_master (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	adc_bus_if.master        bus,
	input  wire logic        i_wr_req,
	input  wire logic [3:0]  i_wr_addr,
	input  wire logic [7:0]  i_wr_data,
	input  wire logic        i_rd_req,
	input  wire logic [3:0]  i_rd_addr,
	input  wire logic        i_word_req,
	input  wire logic [1:0]  i_word_sel,
	output logic             o_busy,
	output logic             o_rd_valid,
	output logic      [15:0] o_rd_data
);
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_HI   = 3'b001,
		M_LO   = 3'b011,
		M_GAP  = 3'b111,
		M_BYTE = 3'b010,
		M_WAIT = 3'b110
	} mst_state_t;

	mst_state_t st_q;
	logic       rd_q;
	logic       wr_q;
	logic [3:0] addr_q;
	logic [7:0] wdata_q;
	logic [15:0] data_q;
	logic       valid_q;
	logic       word_q;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q    <= M_IDLE;
			rd_q    <= 1'b0;
			wr_q    <= 1'b0;
			addr_q  <= 4'h0;
			wdata_q <= 8'h00;
			data_q  <= 16'h0000;
			valid_q <= 1'b0;
			word_q  <= 1'b0;
		end else begin
			rd_q    <= 1'b0;
			wr_q    <= 1'b0;
			valid_q <= 1'b0;
			case (st_q)
				M_IDLE: begin
					if (i_word_req) begin
						// Upper byte first so the latch holds the same result
						rd_q   <= 1'b1;
						addr_q <= {1'b0, i_word_sel, 1'b0};
						word_q <= 1'b1;
						st_q   <= M_HI;
					end else if (i_rd_req) begin
						rd_q   <= 1'b1;
						addr_q <= i_rd_addr;
						word_q <= 1'b0;
						st_q   <= M_BYTE;
					end else if (i_wr_req) begin
						// Done flag is cleared only by a zero in its position
						wr_q    <= 1'b1;
						addr_q  <= i_wr_addr;
						wdata_q <= i_wr_data;
					end
				end
				M_HI: begin
					st_q <= M_LO;
				end
				M_LO: begin
					data_q[15:8] <= bus.rdata;
					rd_q   <= 1'b1;
					addr_q <= addr_q | 4'h1;
					st_q   <= M_GAP;
				end
				// Low byte appears one cycle after its strobe is taken
				M_GAP: begin
					st_q <= M_WAIT;
				end
				M_BYTE: begin
					st_q <= M_WAIT;
				end
				M_WAIT: begin
					if (word_q)
						data_q[7:0] <= bus.rdata;
					else
						data_q <= {8'h00, bus.rdata};
					valid_q <= 1'b1;
					st_q    <= M_IDLE;
				end
				default: st_q <= M_IDLE;
			endcase
		end
	end

	assign bus.rd     = rd_q;
	assign bus.wr     = wr_q;
	assign bus.addr   = addr_q;
	assign bus.wdata  = wdata_q;
	assign o_busy     = st_q != M_IDLE;
	assign o_rd_valid = valid_q;
	assign o_rd_data  = data_q;
endmodule
`default_nettype wire

/* testbench/adc_bus_sva.sv */
// Checker on the byte bus between master and converter
`default_nettype none
module adc_bus_sva (
	input wire logic       i_mclk,
	input wire logic       i_rst_n,
	input wire logic       rd,
	input wire logic       wr,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	logic [7:0] ctl_q, cs_q, lo_q;
	logic [3:0] lo_a_q;
	logic       pend_q, lo_ok_q;
	wire ctl_a = addr == adc_ctl_pkg::ADDR_CONTROL;
	wire cs_a  = addr == adc_ctl_pkg::ADDR_CTL_STATUS;
	wire lo_rd = rd && addr < 4'h8 && addr[0];
	wire hi_rd = rd && addr < 4'h8 && !addr[0];
	// Shadow of written fields; latch value is learned from a first low read
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctl_q <= adc_ctl_pkg::CONTROL_RESET;
			cs_q <= adc_ctl_pkg::CTL_STATUS_RESET;
			lo_q <= 8'h00;
			lo_a_q <= 4'h0;
			pend_q <= 1'b0;
			lo_ok_q <= 1'b0;
		end else begin
			if (wr && ctl_a) ctl_q <= wdata & adc_ctl_pkg::CONTROL_WMASK | adc_ctl_pkg::CONTROL_RSVD;
			if (wr && cs_a) cs_q <= wdata;
			if (lo_rd) lo_a_q <= addr;
			if (pend_q) lo_q <= rdata;
			pend_q <= lo_rd;
			lo_ok_q <= !hi_rd && (pend_q || lo_ok_q);
		end
	end
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	a_rsvd_ones: assert property (rd && ctl_a |=> (rdata & 8'h33) == 8'h33)
		else $error("reserved control bits not one");
	a_ctl_readback: assert property (rd && ctl_a |=> rdata == ctl_q)
		else $error("control readback wrong");
	a_status_fields: assert property (rd && cs_a |=> (rdata & 8'h5F) == (cs_q & 8'h5F))
		else $error("status fields wrong");
	a_low_pad_zero: assert property (lo_rd |=> rdata[5:0] == 6'h00)
		else $error("low result bits not zero");
	a_lo_latched: assert property (lo_rd && lo_ok_q && addr == lo_a_q |=> rdata == lo_q)
		else $error("low byte not from latch");
	a_rdata_stands: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without read");
	a_unmapped_zero: assert property (rd && addr > 4'h9 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_one_strobe: assert property (!(rd && wr))
		else $error("read and write together");
	c_lo_twice: cover property (lo_rd && lo_ok_q);
	c_ctl_read: cover property (rd && ctl_a);
	c_run_write: cover property (wr && cs_a && wdata[5]);
endmodule
`default_nettype wire

/* testbench/adc_trigger_and_result_readout_bench.sv */
// End to end bench: bus master facing converter control
`default_nettype none
module adc_trigger_and_result_readout_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, rst_n = 0, wr_req = 0, rd_req = 0, word_req = 0, timer_pulse_unit = 0, tmr = 0, ext_n = 1;
	logic [3:0]  wa = 0, ra = 0, sel;
	logic [7:0]  wd = 0;
	logic [1:0]  ws = 0;
	logic [9:0]  smp = 0;
	logic [15:0] rdv, v;
	logic        m_busy, rv, d_busy, sv;
	int          err_total = 0, check_count = 0;
	always #2.5 mclk = ~mclk;
	adc_bus_if bus ();
	adc_ctl_device i_adc_ctl_device (.i_mclk(mclk), .i_rst_n(rst_n), .bus(bus), .i_tpu_trig(timer_pulse_unit),
		.i_timer_trig(tmr), .i_ext_trig_n(ext_n), .i_sample(smp), .o_analog_sel(sel), .o_sel_valid(sv),
		.o_busy(d_busy));
	adc_bus_master i_adc_bus_master (.i_mclk(mclk), .i_rst_n(rst_n), .bus(bus), .i_wr_req(wr_req),
		.i_wr_addr(wa), .i_wr_data(wd), .i_rd_req(rd_req), .i_rd_addr(ra), .i_word_req(word_req),
		.i_word_sel(ws), .o_busy(m_busy), .o_rd_valid(rv), .o_rd_data(rdv));
	adc_bus_sva i_adc_bus_sva (.i_mclk(mclk), .i_rst_n(rst_n), .rd(bus.rd), .wr(bus.wr), .addr(bus.addr),
		.wdata(bus.wdata), .rdata(bus.rdata));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr_req <= 1'b1;
		wa <= a;
		wd <= d;
		@(posedge mclk);
		wr_req <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	// Word reads select a result; byte reads land in the low byte
	task automatic rd(input logic w, input logic [3:0] a);
		@(posedge mclk);
		word_req <= w;
		rd_req <= !w;
		ra <= a;
		ws <= a[1:0];
		@(posedge mclk);
		word_req <= 1'b0;
		rd_req <= 1'b0;
		repeat (12) begin
			@(negedge mclk);
			if (rv === 1'b1) break;
		end
		chk("rd_valid", 16'(rv), 16'h1);
		v = rdv;
	endtask
	task automatic rb(input logic [3:0] a, input logic [7:0] e);
		rd(1'b0, a);
		chk("byte", {8'h00, v[7:0]}, {8'h00, e});
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		$display("watchdog expired");
		end_sim();
	end
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		rb(4'h9, 8'h33);
		rb(4'h8, 8'h00);
		rb(4'hA, 8'h00);
		for (int s = 0; s < 16; s++) begin
			wr(4'h9, {s[3:2], 2'b00, s[1:0], 2'b00});
			rb(4'h9, {s[3:2], 2'b11, s[1:0], 2'b11});
		end
		$display("test control register done");
		for (int c = 0; c < 32; c++) begin
			wr(4'h8, {3'b000, c[4:0]});
			@(negedge mclk);
			chk("sel_valid", 16'(sv), 16'(c[3:0] < 4 || (!c[4] && c[3:0] > 13)));
		end
		$display("test channel decode done");
		for (int s = 0; s < 4; s++) begin
			smp <= 10'(s * 300 + 5);
			wr(4'h9, {s[1:0], 6'h3C});
			wr(4'h8, s == 0 ? 8'h21 : 8'h01);
			timer_pulse_unit <= s == 1;
			tmr <= s == 2;
			ext_n <= s != 3;
			repeat (4) @(posedge mclk);
			timer_pulse_unit <= 1'b0;
			tmr <= 1'b0;
			ext_n <= 1'b1;
			@(negedge mclk);
			chk("busy", 16'(d_busy), 16'h1);
			repeat (80) @(posedge mclk);
			rb(4'h8, 8'h81);
			rd(1'b1, 4'h1);
			chk("word", v, {10'(s * 300 + 5), 6'h00});
			wr(4'h8, 8'h01);
			rb(4'h8, 8'h01);
		end
		wr(4'h8, 8'h80);
		rb(4'h8, 8'h00);
		$display("test start sources done");
		rb(4'h2, 8'hE2);
		wr(4'h9, 8'h0C);
		smp <= 10'h3FF;
		wr(4'h8, 8'h21);
		repeat (80) @(posedge mclk);
		rb(4'h3, 8'h40);
		rb(4'h3, 8'h40);
		rd(1'b1, 4'h1);
		chk("word", v, 16'hFFC0);
		$display("test byte latch done");
		smp <= 10'h155;
		wr(4'h8, 8'h31);
		repeat (160) @(posedge mclk);
		rb(4'h8, 8'hB1);
		wr(4'h8, 8'h10);
		rb(4'h8, 8'h10);
		rd(1'b1, 4'h0);
		chk("scan_a", v, 16'h5540);
		rd(1'b1, 4'h1);
		chk("scan_b", v, 16'h5540);
		$display("test scan done");
		end_sim();
	end
endmodule
`default_nettype wire
